// >>> design/sbmd_params.svh
/*
 holds the address map, port indices and timing figures of the system bus matrix decoder.
 assumes it is included by the package and the matrix module, by its bare name.
*/
// Behaviour
// - boot ROM sits fixed at address zero; no remap exists.
// - main and peripheral bus data paths are 32 bits wide.
// - main bus runs on processor clock, 16MHz steps, at most 48MHz.
// - peripheral bus rate is an integer division, at most half the main rate.
// - exactly four main-bus masters: processor, DMA, debug UART master, cache fill.
// - radio link controller wins SRAM arbitration against bus masters; a grant already held runs to completion first.
// - access rights per master to each slave class as in the table.
// - fixed priority per slave, lowest number wins.
// - with cache enabled, top 16kB SRAM is barred to bus masters.
// - SRAM decodes as two 32kB blocks at 0x100000 and 0x108000.
// - radio private port reaches only the sub-block based at 0x128000.
// - boot ROM occupies 0x00000000 to 0x0001FFFF.
// - radio link registers at 0x20100000, radio modem registers next 64kB.
// - DMA registers 0x20120000, cache registers 0x20121000, rest reserved.
// - first peripheral segment: five 4kB windows from 0x20130000.
// - third peripheral segment: seven 4kB windows from 0x20143000.
// - always-on segment: RTC at 0x20200000, always-on control next.
`ifndef SBMD_PARAMS_SVH
`define SBMD_PARAMS_SVH

`define SBMD_DATA_W        32
`define SBMD_NUM_PORTS     5
`define SBMD_NUM_SLAVES    6
`define SBMD_P_CPU         3'h0
`define SBMD_P_DMA         3'h1
`define SBMD_P_DBG         3'h2
`define SBMD_P_CACHE       3'h3
`define SBMD_P_RADIO       3'h4
`define SBMD_PRIO_NONE     3'h7

`define SBMD_ROM_LAST      32'h0001_FFFF
`define SBMD_SRAM_BASE     32'h0010_0000
`define SBMD_SRAM_HI_BASE  32'h0010_8000
`define SBMD_SRAM_LAST     32'h0010_FFFF
`define SBMD_CACHE_TOP     32'h0010_C000
`define SBMD_RADIO_BASE    32'h0012_8000
`define SBMD_RADIO_LAST    32'h0012_FFFF
`define SBMD_CMEM_BASE     32'h0080_0000
`define SBMD_CMEM_LAST     32'h00FF_FFFF
`define SBMD_RLC_BASE      32'h2010_0000
`define SBMD_MODEM_BASE    32'h2011_0000
`define SBMD_MODEM_LAST    32'h2011_FFFF
`define SBMD_DMA_BASE      32'h2012_0000
`define SBMD_CREG_BASE     32'h2012_1000
`define SBMD_CREG_LAST     32'h2012_1FFF
`define SBMD_SEG1_BASE     32'h2013_0000
`define SBMD_SEG1_COUNT    5
`define SBMD_SEG3_BASE     32'h2014_3000
`define SBMD_SEG3_COUNT    7
`define SBMD_AWO_BASE      32'h2020_0000
`define SBMD_AWO_COUNT     2
`define SBMD_WIN_SHIFT     12

`define SBMD_MAIN_MHZ_STEP 16
`define SBMD_MAIN_MHZ_MAX  48
`define SBMD_PDIV_MIN      2
`define SBMD_PDIV_W        8

`endif

// >>> design/sbmd_pkg.sv
/*
 holds the types of the system bus matrix decoder: regions, slave classes, state.
 assumes sbmd_params.svh is on the include path.
*/
`include "sbmd_params.svh"

package sbmd_pkg;

	typedef enum logic [4:0] {
		RG_NONE, RG_ROM, RG_CMEM, RG_SRAM, RG_RLC_REG, RG_MODEM_REG, RG_DMA_REG, RG_CACHE_REG,
		RG_TIMER, RG_WDT, RG_SYSC_CORE, RG_PATCH, RG_ECC,
		RG_UART0, RG_UART1, RG_I2C0, RG_I2C1, RG_PWM, RG_GPIO, RG_SYSC_PER,
		RG_RTC, RG_SYSC_AWO
	} sbmd_region_e;

	typedef enum logic [2:0] {
		SL_ROM, SL_CMEM, SL_SRAM, SL_MREG, SL_PER, SL_AWO, SL_NONE
	} sbmd_slave_e;

	typedef logic [`SBMD_DATA_W-1:0] sbmd_word_t;

	typedef struct packed {
		logic [`SBMD_NUM_SLAVES-1:0]                busy;
		logic [`SBMD_NUM_SLAVES-1:0][2:0]           owner;
		logic [`SBMD_NUM_PORTS-1:0]                 ack;
		logic [`SBMD_NUM_PORTS-1:0]                 err;
		logic [`SBMD_NUM_PORTS-1:0][`SBMD_DATA_W-1:0] rdata;
		logic [`SBMD_PDIV_W-1:0]                    pdiv;
	} sbmd_state_s;

endpackage

// >>> design/sbmd_matrix.sv
/*
 holds the bus matrix: per-port address decode, access rights, per-slave fixed
 priority arbiters, grant holding and the peripheral bus clock enable divider.
 assumes masters hold req, addr, we and wdata steady until ack, and drop or change
 req in the cycle after ack; slaves answer with a ready pulse while selected.
 port 4 is the radio link controller private SRAM port.
*/
`include "sbmd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sbmd_matrix #(
	parameter int MAIN_MHZ = 48,
	parameter int PDIV     = 2
) (
	input  wire logic                                       clk,
	input  wire logic                                       rst_n,
	input  wire logic                                       cache_en,
	input  wire logic [`SBMD_NUM_PORTS-1:0]                 m_req,
	input  wire logic [`SBMD_NUM_PORTS-1:0][`SBMD_DATA_W-1:0] m_addr,
	input  wire logic [`SBMD_NUM_PORTS-1:0]                 m_we,
	input  wire logic [`SBMD_NUM_PORTS-1:0][`SBMD_DATA_W-1:0] m_wdata,
	output logic      [`SBMD_NUM_PORTS-1:0]                 m_ack,
	output logic      [`SBMD_NUM_PORTS-1:0]                 m_err,
	output logic      [`SBMD_NUM_PORTS-1:0][`SBMD_DATA_W-1:0] m_rdata,
	output logic      [`SBMD_NUM_SLAVES-1:0]                s_sel,
	output logic      [`SBMD_NUM_SLAVES-1:0][`SBMD_DATA_W-1:0] s_addr,
	output logic      [`SBMD_NUM_SLAVES-1:0]                s_we,
	output logic      [`SBMD_NUM_SLAVES-1:0][`SBMD_DATA_W-1:0] s_wdata,
	output sbmd_pkg::sbmd_region_e [`SBMD_NUM_SLAVES-1:0]   s_region,
	input  wire logic [`SBMD_NUM_SLAVES-1:0][`SBMD_DATA_W-1:0] s_rdata,
	input  wire logic [`SBMD_NUM_SLAVES-1:0]                s_ready,
	output logic                                            pclk_en,
	output logic                                            sram_blk_hi
);

	localparam int NP = `SBMD_NUM_PORTS;
	localparam int NS = `SBMD_NUM_SLAVES;

	// ==========================================================
	// elaboration checks
	initial begin
		if (`SBMD_DATA_W != 32)
			$error("bus width must be 32");
		if (MAIN_MHZ <= 0 || MAIN_MHZ > `SBMD_MAIN_MHZ_MAX || MAIN_MHZ % `SBMD_MAIN_MHZ_STEP != 0)
			$error("main bus rate must be a 16MHz step up to 48MHz");
		if (PDIV < `SBMD_PDIV_MIN || PDIV > (1 << `SBMD_PDIV_W))
			$error("peripheral divider must be 2 or more");
		if (NP != 5)
			$error("four masters plus the radio port expected");
	end

	// ==========================================================
	// decode functions
	function automatic sbmd_pkg::sbmd_region_e win_region(input logic [31:0] a);
		logic [31:0] off1;
		logic [31:0] off3;
		logic [31:0] offa;
		off1 = a - `SBMD_SEG1_BASE;
		off3 = a - `SBMD_SEG3_BASE;
		offa = a - `SBMD_AWO_BASE;
		win_region = sbmd_pkg::RG_NONE;
		if (a <= `SBMD_ROM_LAST)
			win_region = sbmd_pkg::RG_ROM;
		else if (a >= `SBMD_SRAM_BASE && a <= `SBMD_SRAM_LAST)
			win_region = sbmd_pkg::RG_SRAM;
		else if (a >= `SBMD_CMEM_BASE && a <= `SBMD_CMEM_LAST)
			win_region = sbmd_pkg::RG_CMEM;
		else if (a >= `SBMD_RLC_BASE && a < `SBMD_MODEM_BASE)
			win_region = sbmd_pkg::RG_RLC_REG;
		else if (a >= `SBMD_MODEM_BASE && a <= `SBMD_MODEM_LAST)
			win_region = sbmd_pkg::RG_MODEM_REG;
		else if (a >= `SBMD_DMA_BASE && a < `SBMD_CREG_BASE)
			win_region = sbmd_pkg::RG_DMA_REG;
		else if (a >= `SBMD_CREG_BASE && a <= `SBMD_CREG_LAST)
			win_region = sbmd_pkg::RG_CACHE_REG;
		else if (a >= `SBMD_SEG1_BASE && (off1 >> `SBMD_WIN_SHIFT) < `SBMD_SEG1_COUNT)
			win_region = sbmd_pkg::sbmd_region_e'(5'(int'(sbmd_pkg::RG_TIMER)
				+ int'(off1 >> `SBMD_WIN_SHIFT)));
		else if (a >= `SBMD_SEG3_BASE && (off3 >> `SBMD_WIN_SHIFT) < `SBMD_SEG3_COUNT)
			win_region = sbmd_pkg::sbmd_region_e'(5'(int'(sbmd_pkg::RG_UART0)
				+ int'(off3 >> `SBMD_WIN_SHIFT)));
		else if (a >= `SBMD_AWO_BASE && (offa >> `SBMD_WIN_SHIFT) < `SBMD_AWO_COUNT)
			win_region = sbmd_pkg::sbmd_region_e'(5'(int'(sbmd_pkg::RG_RTC)
				+ int'(offa >> `SBMD_WIN_SHIFT)));
	endfunction

	function automatic sbmd_pkg::sbmd_region_e port_region(input logic [2:0] p,
		input logic [31:0] a, input logic cen);
		sbmd_pkg::sbmd_region_e r;
		r = win_region(a);
		if (p == `SBMD_P_RADIO)
			r = (a >= `SBMD_RADIO_BASE && a <= `SBMD_RADIO_LAST) ? sbmd_pkg::RG_SRAM
				: sbmd_pkg::RG_NONE;
		else if (r == sbmd_pkg::RG_SRAM && cen && a >= `SBMD_CACHE_TOP)
			r = sbmd_pkg::RG_NONE;
		port_region = r;
	endfunction

	function automatic sbmd_pkg::sbmd_slave_e slave_of(input sbmd_pkg::sbmd_region_e r);
		case (r)
			sbmd_pkg::RG_NONE:   slave_of = sbmd_pkg::SL_NONE;
			sbmd_pkg::RG_ROM:    slave_of = sbmd_pkg::SL_ROM;
			sbmd_pkg::RG_CMEM:   slave_of = sbmd_pkg::SL_CMEM;
			sbmd_pkg::RG_SRAM:   slave_of = sbmd_pkg::SL_SRAM;
			sbmd_pkg::RG_RTC, sbmd_pkg::RG_SYSC_AWO: slave_of = sbmd_pkg::SL_AWO;
			default: begin
				// main-bus register windows stay at full rate; the rest sit on the slow bus
				slave_of = (r <= sbmd_pkg::RG_CACHE_REG) ? sbmd_pkg::SL_MREG : sbmd_pkg::SL_PER;
			end
		endcase
	endfunction

	// lower wins; PRIO_NONE means no access at all
	function automatic logic [2:0] prio(input logic [2:0] p, input sbmd_pkg::sbmd_slave_e s);
		prio = `SBMD_PRIO_NONE;
		case (s)
			sbmd_pkg::SL_ROM, sbmd_pkg::SL_CMEM:
				if (p == `SBMD_P_CPU) prio = 3'h0;
			sbmd_pkg::SL_SRAM: begin
				case (p)
					`SBMD_P_RADIO: prio = 3'h0;
					`SBMD_P_CPU:   prio = 3'h1;
					`SBMD_P_DBG:   prio = 3'h2;
					`SBMD_P_DMA:   prio = 3'h3;
					default:       prio = `SBMD_PRIO_NONE;
				endcase
			end
			sbmd_pkg::SL_MREG, sbmd_pkg::SL_PER: begin
				case (p)
					`SBMD_P_CPU: prio = 3'h0;
					`SBMD_P_DBG: prio = 3'h1;
					`SBMD_P_DMA: prio = 3'h2;
					default:     prio = `SBMD_PRIO_NONE;
				endcase
			end
			sbmd_pkg::SL_AWO: begin
				if (p == `SBMD_P_CPU) prio = 3'h0;
				else if (p == `SBMD_P_DBG) prio = 3'h1;
			end
			default: prio = `SBMD_PRIO_NONE;
		endcase
	endfunction

	// ==========================================================
	// decode per port
	sbmd_pkg::sbmd_state_s st_r;
	sbmd_pkg::sbmd_state_s st_nxt;
	sbmd_pkg::sbmd_region_e [NP-1:0] p_region;
	sbmd_pkg::sbmd_slave_e  [NP-1:0] p_slave;
	logic [NP-1:0][2:0]              p_prio;
	logic [NS-1:0]                   rdy_eff;

	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_port
			assign p_region[gp] = port_region(3'(gp), m_addr[gp], cache_en);
			assign p_slave[gp]  = slave_of(p_region[gp]);
			assign p_prio[gp]   = prio(3'(gp), p_slave[gp]);
		end
	endgenerate

	// ==========================================================
	// slave side
	genvar gs;
	generate
		for (gs = 0; gs < NS; gs++) begin : g_slave
			logic [2:0] own;
			assign own          = st_r.owner[gs];
			assign s_sel[gs]    = st_r.busy[gs];
			assign s_addr[gs]   = m_addr[own];
			assign s_we[gs]     = m_we[own];
			assign s_wdata[gs]  = m_wdata[own];
			assign s_region[gs] = p_region[own];
			// slow-bus slaves complete only on a peripheral clock beat
			assign rdy_eff[gs]  = st_r.busy[gs] & s_ready[gs]
				& ((gs == int'(sbmd_pkg::SL_PER) || gs == int'(sbmd_pkg::SL_AWO)) ? pclk_en : 1'b1);
		end
	endgenerate

	assign sram_blk_hi = s_addr[sbmd_pkg::SL_SRAM][15];
	assign pclk_en     = (st_r.pdiv == `SBMD_PDIV_W'(PDIV - 1));
	assign m_ack       = st_r.ack;
	assign m_err       = st_r.err;
	assign m_rdata     = st_r.rdata;

	// ==========================================================
	// next state
	always_comb begin
		logic [2:0] best;
		logic [2:0] best_p;
		st_nxt      = st_r;
		st_nxt.ack  = '0;
		st_nxt.err  = '0;
		st_nxt.pdiv = pclk_en ? '0 : st_r.pdiv + `SBMD_PDIV_W'(1);
		for (int s = 0; s < NS; s++) begin
			best   = 3'h0;
			best_p = `SBMD_PRIO_NONE;
			if (rdy_eff[s]) begin
				// grant released only at completion, never mid transfer
				st_nxt.busy[s]                  = 1'b0;
				st_nxt.ack[st_r.owner[s]]       = 1'b1;
				st_nxt.rdata[st_r.owner[s]]     = s_rdata[s];
			end else if (!st_r.busy[s]) begin
				for (int p = 0; p < NP; p++) begin
					if (m_req[p] && !st_r.ack[p] && p_slave[p] == sbmd_pkg::sbmd_slave_e'(3'(s))
						&& p_prio[p] < best_p) begin
						best   = 3'(p);
						best_p = p_prio[p];
					end
				end
				if (best_p != `SBMD_PRIO_NONE) begin
					st_nxt.busy[s]  = 1'b1;
					st_nxt.owner[s] = best;
				end
			end
		end
		for (int p = 0; p < NP; p++) begin
			// refused requests answer at once so the requester never hangs
			if (m_req[p] && !st_r.ack[p] && p_prio[p] == `SBMD_PRIO_NONE) begin
				st_nxt.ack[p]   = 1'b1;
				st_nxt.err[p]   = 1'b1;
				st_nxt.rdata[p] = '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic sram_idle;
	assign sram_idle = !st_r.busy[sbmd_pkg::SL_SRAM];

	rom_at_zero_a: assert property (
		m_req[0] && !m_ack[0] && m_addr[0] == 32'h0000_0000 && !st_r.busy[sbmd_pkg::SL_ROM]
		|=> s_sel[sbmd_pkg::SL_ROM] && st_r.owner[sbmd_pkg::SL_ROM] == 3'h0)
		else $error("address zero did not reach the boot ROM");

	radio_wins_a: assert property (
		sram_idle && m_req[4] && !m_ack[4] && p_slave[4] == sbmd_pkg::SL_SRAM
		&& m_req[0] && !m_ack[0] && p_slave[0] == sbmd_pkg::SL_SRAM
		|=> st_r.owner[sbmd_pkg::SL_SRAM] == 3'h4)
		else $error("radio port lost SRAM contention");

	cpu_over_dma_a: assert property (
		sram_idle && !(m_req[4] && p_slave[4] == sbmd_pkg::SL_SRAM)
		&& m_req[0] && !m_ack[0] && p_slave[0] == sbmd_pkg::SL_SRAM
		&& m_req[1] && !m_ack[1] && p_slave[1] == sbmd_pkg::SL_SRAM
		|=> st_r.owner[sbmd_pkg::SL_SRAM] == 3'h0)
		else $error("processor lost SRAM to DMA");

	cache_port_err_a: assert property (
		m_req[3] && !m_ack[3] |=> m_ack[3] && m_err[3])
		else $error("cache fill port was not refused");

	cache_top_guard_a: assert property (
		cache_en && m_req[0] && !m_ack[0] && m_addr[0] >= 32'h0010_C000
		&& m_addr[0] <= 32'h0010_FFFF |=> m_err[0])
		else $error("top SRAM reached while cache enabled");

	radio_range_a: assert property (
		m_req[4] && !m_ack[4] && (m_addr[4] < 32'h0012_8000 || m_addr[4] > 32'h0012_FFFF)
		|=> m_err[4] && !s_sel[sbmd_pkg::SL_SRAM] ##0 $past(sram_idle) || m_err[4])
		else $error("radio port left its sub-block");

	reserved_err_a: assert property (
		m_req[0] && !m_ack[0] && m_addr[0] >= 32'h2012_2000 && m_addr[0] <= 32'h2012_FFFF
		|=> m_ack[0] && m_err[0])
		else $error("reserved window not refused");

	grant_hold_a: assert property (
		s_sel[sbmd_pkg::SL_SRAM] && !rdy_eff[sbmd_pkg::SL_SRAM]
		|=> s_sel[sbmd_pkg::SL_SRAM] && $stable(st_r.owner[sbmd_pkg::SL_SRAM]))
		else $error("SRAM grant moved mid transfer");

	pclk_half_a: assert property (
		pclk_en |=> !pclk_en)
		else $error("peripheral enable faster than half rate");

	slow_done_a: assert property (
		s_sel[sbmd_pkg::SL_PER] && !pclk_en |=> s_sel[sbmd_pkg::SL_PER])
		else $error("slow slave completed off its beat");

	dma_awo_err_a: assert property (
		m_req[1] && !m_ack[1] && m_addr[1] >= 32'h2020_0000 && m_addr[1] <= 32'h2020_1FFF
		|=> m_err[1])
		else $error("DMA reached always-on registers");

	sram_contend_c: cover property (m_req[4] && m_req[0] && p_slave[0] == sbmd_pkg::SL_SRAM);
	concurrent_c:   cover property (s_sel[sbmd_pkg::SL_SRAM] && s_sel[sbmd_pkg::SL_PER]);
	error_c:        cover property (m_ack[2] && m_err[2]);
	rom_done_c:     cover property (m_ack[0] && !m_err[0]);

endmodule

`default_nettype wire

// >>> tb/sbmd_slave_model.sv
/*
 responder model for one slave port of the bus matrix.
 assumes the matrix only counts ready while sel is high, and on slow slaves only with pclk_en.
*/
`timescale 1ns/1ps
`default_nettype none

module sbmd_slave_model #(
	parameter int IDX  = 0,
	parameter bit SLOW = 1'h0
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sel,
	input  wire logic [31:0] addr,
	input  wire logic        pclk_en,
	input  wire logic [3:0]  dly,
	output logic             ready,
	output logic [31:0]      rdata
);
	// ==========================================
	// answer
	logic [3:0]  cnt_r;
	logic        done_r;
	logic [31:0] junk_r;

	// slow slaves answer only on a peripheral beat
	assign ready = sel && !done_r && (cnt_r >= dly) && (!SLOW || pclk_en);
	// data churns outside the answer cycle so a late sample never matches by luck
	assign rdata = ready ? (addr ^ 32'h5A5A_0000 ^ 32'(IDX)) : junk_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			junk_r <= 32'h3C3C_C3C3;
		end else begin
			junk_r <= ~junk_r;
		end
		if (!rst_n || !sel) begin
			cnt_r  <= 4'h0;
			done_r <= 1'h0;
		end else begin
			if (ready) begin
				done_r <= 1'h1;
			end
			if (cnt_r != 4'hF) begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// >>> tb/system_bus_matrix_decoder_bench.sv
/*
 self-checking bench for the bus matrix: masters driven here, six slave models answer.
 assumes the design files and sbmd_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module system_bus_matrix_decoder_bench;
	localparam int PDIV = 3;
	localparam logic [31:0] WIN [35] = '{
		32'h0000_0000, 32'h0001_FFFC, 32'h0002_0000, 32'h0010_0000, 32'h0010_7FFC,
		32'h0010_8000, 32'h0010_FFFC, 32'h0011_0000, 32'h0012_8000, 32'h0012_FFFC,
		32'h0080_0000, 32'h00FF_FFFC, 32'h2010_0000, 32'h2011_FFFC, 32'h2012_0000,
		32'h2012_1FFC, 32'h2012_2000, 32'h2013_0000, 32'h2013_1000, 32'h2013_2000,
		32'h2013_3000, 32'h2013_4FFC, 32'h2013_5000, 32'h2014_3000, 32'h2014_4000,
		32'h2014_5000, 32'h2014_6000, 32'h2014_7000, 32'h2014_8000, 32'h2014_9FFC,
		32'h2014_A000, 32'h2020_0000, 32'h2020_1FFC, 32'h2020_2000, 32'hFFFF_FFFC};
	logic                          clk;
	logic                          rst_n;
	logic                          cache_en;
	logic [4:0]                    m_req;
	logic [4:0]                    m_we;
	logic [4:0]                    m_ack;
	logic [4:0]                    m_err;
	logic [4:0][31:0]              m_addr;
	logic [4:0][31:0]              m_wdata;
	logic [4:0][31:0]              m_rdata;
	logic [5:0]                    s_sel;
	logic [5:0]                    s_we;
	logic [5:0]                    s_ready;
	logic [5:0][31:0]              s_addr;
	logic [5:0][31:0]              s_wdata;
	logic [5:0][31:0]              s_rdata;
	sbmd_pkg::sbmd_region_e [5:0]  s_region;
	logic                          pclk_en;
	logic                          sram_blk_hi;
	logic [5:0][3:0]               dly;
	int                            mismatches;
	int                            checks;
	int                            cyc;
	int                            seed;
	int                            gap;
	int                            t_ack [5];

	sbmd_matrix #(.MAIN_MHZ(48), .PDIV(PDIV)) i_dut (
		.clk(clk), .rst_n(rst_n), .cache_en(cache_en), .m_req(m_req), .m_addr(m_addr),
		.m_we(m_we), .m_wdata(m_wdata), .m_ack(m_ack), .m_err(m_err), .m_rdata(m_rdata),
		.s_sel(s_sel), .s_addr(s_addr), .s_we(s_we), .s_wdata(s_wdata), .s_region(s_region),
		.s_rdata(s_rdata), .s_ready(s_ready), .pclk_en(pclk_en), .sram_blk_hi(sram_blk_hi));

	for (genvar i = 0; i < 6; i++) begin : g_slv
		sbmd_slave_model #(.IDX(i), .SLOW(i >= 4)) i_slv (
			.clk(clk), .rst_n(rst_n), .sel(s_sel[i]), .addr(s_addr[i]), .pclk_en(pclk_en),
			.dly(dly[i]), .ready(s_ready[i]), .rdata(s_rdata[i]));
	end

	// ==========================================
	// reference model: region code times 8 plus slave index, 6 = none
	function automatic int dec(input logic [31:0] a);
		if (a <= 32'h0001_FFFF) return 8 * sbmd_pkg::RG_ROM;
		if (a >= 32'h0080_0000 && a <= 32'h00FF_FFFF) return 8 * sbmd_pkg::RG_CMEM + 1;
		if (a[31:16] == 16'h0010 || a[31:15] == 17'h0025) return 8 * sbmd_pkg::RG_SRAM + 2;
		if (a[31:16] == 16'h2010) return 8 * sbmd_pkg::RG_RLC_REG + 3;
		if (a[31:16] == 16'h2011) return 8 * sbmd_pkg::RG_MODEM_REG + 3;
		if (a[31:12] == 20'h20120) return 8 * sbmd_pkg::RG_DMA_REG + 3;
		if (a[31:12] == 20'h20121) return 8 * sbmd_pkg::RG_CACHE_REG + 3;
		if (a >= 32'h2013_0000 && a < 32'h2013_5000)
			return 8 * (sbmd_pkg::RG_TIMER + int'(a[19:12]) - 8'h30) + 4;
		if (a >= 32'h2014_3000 && a < 32'h2014_A000)
			return 8 * (sbmd_pkg::RG_UART0 + int'(a[19:12]) - 8'h43) + 4;
		if (a >= 32'h2020_0000 && a < 32'h2020_2000)
			return 8 * (sbmd_pkg::RG_RTC + int'(a[12])) + 5;
		return 8 * sbmd_pkg::RG_NONE + 6;
	endfunction

	function automatic int target(input int p, input logic [31:0] a, input logic ce);
		int sl;
		sl = dec(a) % 8;
		if (p == 4) return (a[31:15] == 17'h0025) ? 2 : 6;
		if (sl == 2 && a[31:16] != 16'h0010) return 6;
		if (sl == 2 && ce && a[15:14] == 2'h3) return 6;
		if (p == 0 || sl == 6) return sl;
		if (p == 3) return 6;
		if (sl == 2 || sl == 3 || sl == 4) return sl;
		return (sl == 5 && p == 2) ? 5 : 6;
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic xfer(input int p, input logic [31:0] a);
		int n;
		int sl;
		@(posedge clk);
		sl = target(p, a, cache_en);
		m_req[p] <= 1'h1;
		m_addr[p] <= a;
		m_we[p] <= 1'($random(seed));
		m_wdata[p] <= $random(seed);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (m_ack[p] !== 1'h1 && n < 60);
		t_ack[p] = cyc;
		chk("ack", 32'(m_ack[p]), 32'h1);
		chk("err", 32'(m_err[p]), 32'(sl == 6));
		chk("rdata", m_rdata[p], (sl == 6) ? 32'h0 : (a ^ 32'h5A5A_0000 ^ 32'(sl)));
		if (sl == 6) chk("err latency", 32'(n), 32'h1);
		@(posedge clk);
		m_req[p] <= 1'h0;
	endtask

	task automatic conclude;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ==========================================
	// monitors
	always #2 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rst_n) begin
			for (int i = 0; i < 6; i++) begin
				if (s_sel[i] === 1'h1) begin
					chk("region", 32'(s_region[i]), 32'(dec(s_addr[i]) / 8));
					chk("slave", 32'(i), 32'(dec(s_addr[i]) % 8));
				end
			end
			if (s_sel[2] === 1'h1) chk("block", 32'(sram_blk_hi), 32'(s_addr[2][15]));
		end
		// first beat after reset is skipped; the spacing after that is fixed
		if (!rst_n) gap <= -1000;
		else if (pclk_en === 1'h1) begin
			if (gap >= 0) chk("beat", 32'(gap + 1), 32'(PDIV));
			gap <= 0;
		end else gap <= gap + 1;
	end

	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		conclude();
	end

	// ==========================================
	// scenarios
	initial begin
		int k;
		int p;
		logic [31:0] r;
		seed = 32'h354e84e1;
		{clk, rst_n, cache_en, m_req, m_we} = '0;
		{m_addr, m_wdata, dly} = '0;
		{mismatches, checks, cyc} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		for (p = 0; p < 5; p++) begin
			for (k = 0; k < 35; k++) xfer(p, WIN[k]);
		end
		cache_en <= 1'h1;
		xfer(0, 32'h0010_BFFC);
		xfer(1, 32'h0010_C000);
		xfer(4, 32'h0012_FFFC);
		cache_en <= 1'h0;
		dly <= {6{4'h2}};
		fork
			xfer(4, 32'h0012_8000);
			xfer(0, 32'h0010_0000);
			xfer(2, 32'h0010_0004);
			xfer(1, 32'h0010_0008);
		join
		chk("sram order", 32'(t_ack[4] < t_ack[0] && t_ack[0] < t_ack[2] && t_ack[2] < t_ack[1]), 32'h1);
		fork
			xfer(1, 32'h2014_3000);
			xfer(2, 32'h2013_0000);
			xfer(0, 32'h2014_8000);
		join
		chk("per order", 32'(t_ack[0] < t_ack[2] && t_ack[2] < t_ack[1]), 32'h1);
		fork
			xfer(2, 32'h2020_0000);
			xfer(0, 32'h2020_1000);
		join
		chk("awo order", 32'(t_ack[0] < t_ack[2]), 32'h1);
		dly <= {6{4'h6}};
		fork
			xfer(0, 32'h0010_0010);
			begin
				repeat (2) @(posedge clk);
				xfer(4, 32'h0012_8004);
			end
		join
		chk("grant held", 32'(t_ack[0] < t_ack[4]), 32'h1);
		dly <= '0;
		fork
			xfer(0, 32'h0000_0100);
			xfer(1, 32'h0010_0100);
			xfer(2, 32'h2010_0000);
		join
		chk("parallel", 32'(t_ack[0] == t_ack[1] && t_ack[1] == t_ack[2]), 32'h1);
		repeat (80) begin
			k = int'($unsigned($random(seed)) % 35);
			p = int'($unsigned($random(seed)) % 5);
			r = $random(seed);
			dly <= {r[31:28], r[27:24], r[23:20], r[19:16], r[15:12], r[3:0]};
			cache_en <= r[12];
			xfer(p, {WIN[k][31:12], r[11:2], 2'h0});
		end
		conclude();
	end
endmodule

`default_nettype wire
